/* ssf_pkg.sv */
// constants for the serial status flag block
package ssf_pkg;
  // ****************************************************
  // register byte offsets on the control bus
  // ****************************************************
  localparam logic [7:0] A_CTRL = 8'he4;
  localparam logic [7:0] A_STAT = 8'he8;
  localparam logic [7:0] A_DATA = 8'hec;
  localparam logic [7:0] A_IRQ_ST = 8'hf0;
  localparam logic [7:0] A_IRQ_MASK = 8'hf4;
  // ****************************************************
  // field positions
  // ****************************************************
  localparam int B_DONE = 'h7;
  localparam int B_WRITE_COLLISION_FLAG = 'h6;
  localparam int B_MODE_FAULT_FLAG = 'h5;
  localparam int B_TXE = 'h4;
  localparam int B_SELECT_IGNORE = 'h2;
  localparam int B_SLAVE_OUT_DISABLE = 'h1;
  localparam int B_ENH = 'h0;
  localparam int B_ESP = 'h7;
  localparam int B_EN = 'h6;
  localparam int B_MASTER_SELECT = 'h4;
  localparam int I_DONE = 'h0;
  localparam int I_MODE_FAULT_FLAG = 'h1;
  localparam int I_TXE = 'h2;
  // ****************************************************
  // reset values, responses and timing
  // ****************************************************
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_HZ = 'd20_000_000;
  localparam int SCK_DIV = 'h4;
  localparam logic [1:0] SCK_HALF = 2'(SCK_DIV / 2 - 1);
  localparam logic [2:0] LAST_BIT = 3'h7;
endpackage

/* ssf_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ssf_sync #(
  parameter int W = 4
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic [W-1:0] din, // asynchronous inputs
  output logic [W-1:0] dout // synchronised copy
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ssf_sync_s;
  ssf_sync_s r;
  ssf_sync_s next_r;
  // first stage feeds only the second stage
  always_comb begin
    next_r = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
  assign dout = r.s2;
endmodule

/* ssf_axil.sv */
// axi4-lite slave front end for the serial status block
`timescale 1ns/1ps
module ssf_axil (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [7:0] awaddr, // write address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [7:0] araddr, // read address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic wr_stb, // register write pulse
  output logic [7:0] wr_addr, // register write address
  output logic [7:0] wr_data, // register write byte
  output logic wr_be, // low byte enabled
  input wire logic wr_err, // write address unmapped
  output logic rd_stb, // register read pulse
  output logic [7:0] rd_addr, // register read address
  input wire logic [31:0] rd_word, // register read value
  input wire logic rd_err // read address unmapped
);
  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic [7:0] awa;
    logic [7:0] wd;
    logic wbe;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } ssf_axil_s;
  ssf_axil_s r;
  ssf_axil_s next_r;
  // write strobe fires once both halves are held
  assign wr_stb = ce & r.aw_have & r.w_have;
  assign wr_addr = r.awa;
  assign wr_data = r.wd;
  assign wr_be = r.wbe;
  assign rd_stb = ce & arvalid & r.arrdy;
  assign rd_addr = araddr;
  // channel handshakes, address and data in either order
  always_comb begin
    next_r = r;
    if (awvalid && r.awrdy) begin
      next_r.aw_have = 1'b1;
      next_r.awa = awaddr;
    end
    if (wvalid && r.wrdy) begin
      next_r.w_have = 1'b1;
      next_r.wd = wdata[7:0];
      next_r.wbe = wstrb[0];
    end
    if (bready && r.bv) begin
      next_r.bv = 1'b0;
    end
    if (r.aw_have && r.w_have) begin
      next_r.aw_have = 1'b0;
      next_r.w_have = 1'b0;
      next_r.bv = 1'b1;
      next_r.br = wr_err ? ssf_pkg::RESP_SLVERR : ssf_pkg::RESP_OKAY;
    end
    if (rready && r.rv) begin
      next_r.rv = 1'b0;
    end
    if (arvalid && r.arrdy) begin
      next_r.rv = 1'b1;
      next_r.rd = rd_word;
      next_r.rr = rd_err ? ssf_pkg::RESP_SLVERR : ssf_pkg::RESP_OKAY;
    end
    // one write and one read under way at most
    next_r.awrdy = ~next_r.aw_have & ~next_r.bv & ~r.aw_have;
    next_r.wrdy = ~next_r.w_have & ~next_r.bv & ~r.w_have;
    next_r.arrdy = ~next_r.rv;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.awrdy <= 1'b1;
      r.wrdy <= 1'b1;
      r.arrdy <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end
  assign awready = r.awrdy;
  assign wready = r.wrdy;
  assign arready = r.arrdy;
  assign bvalid = r.bv;
  assign bresp = r.br;
  assign rvalid = r.rv;
  assign rdata = r.rd;
  assign rresp = r.rr;
endmodule

/* ssf_spi_status.sv */
// serial unit with status flags, interrupt and mode 0 shifter
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - transfer end sets done, interrupts if enabled
// - done clears by write or status-data sequence
// - write while buffer full flags collision only
// - collision clears by write or status-data sequence
// - master with select low sets mode fault
// - mode fault clears only by software write
// - buffer-to-shifter move sets tx empty flag
// - tx empty interrupts only with both enables
// - slave active only while select low
// - select ignore disregards select, no mode fault
// - slave output disable tristates miso
// - data write loads buffer, master starts
// - data read returns last byte, overwritten
module ssf_spi_status (
  input wire logic aclk, // system clock, 20 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable, freezes all
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [7:0] awaddr, // write address
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  output logic [1:0] bresp, // write response
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  input wire logic [7:0] araddr, // read address
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  input wire logic sck_in, // serial clock pin in
  output logic sck_out, // serial clock pin out
  output logic sck_oe, // serial clock drive enable
  input wire logic mosi_in, // master-out pin in
  output logic mosi_out, // master-out pin out
  output logic mosi_oe, // master-out drive enable
  input wire logic miso_in, // master-in pin in
  output logic miso_out, // master-in pin out
  output logic miso_oe, // master-in drive enable
  input wire logic ss_n_in, // slave select pin, low
  output logic irq // level interrupt
);
  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic en;
    logic master_select;
    logic serial_irq_enable;
    logic done;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic tx_empty_flag;
    logic select_ignore;
    logic slave_out_disable;
    logic tx_empty_irq_enable;
    logic armed;
    logic [7:0] txbuf;
    logic txfull;
    logic [7:0] shreg;
    logic [7:0] rxbuf;
    logic samp;
    logic [2:0] bits;
    logic busy;
    logic [1:0] div;
    logic sck;
    logic sck_prev;
    logic [2:0] pend;
    logic [2:0] mask;
    logic irq;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic sck_oe;
  } ssf_core_s;
  ssf_core_s r;
  ssf_core_s next_r;
  logic [3:0] pins_s;
  logic ss_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_be;
  logic rd_stb;
  logic [7:0] rd_addr;
  logic [31:0] rd_word;
  logic ctl_wr;
  logic st_wr;
  logic dat_wr;
  logic msk_wr;
  logic st_rd;
  logic dat_rd;
  logic ist_rd;
  logic dat_acc;
  logic slave_on;
  logic rise_e;
  logic fall_e;
  logic xfer_end;
  logic mfault;
  logic [7:0] rxin;
  // ****************************************************
  // address decode and read mux
  // ****************************************************
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == ssf_pkg::A_CTRL) || (a == ssf_pkg::A_STAT) ||
      (a == ssf_pkg::A_DATA) || (a == ssf_pkg::A_IRQ_ST) ||
      (a == ssf_pkg::A_IRQ_MASK);
  endfunction
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    rd_mux = 8'h00;
    if (a == ssf_pkg::A_CTRL) begin
      rd_mux[ssf_pkg::B_ESP] = r.serial_irq_enable;
      rd_mux[ssf_pkg::B_EN] = r.en;
      rd_mux[ssf_pkg::B_MASTER_SELECT] = r.master_select;
    end else if (a == ssf_pkg::A_STAT) begin
      rd_mux[ssf_pkg::B_DONE] = r.done;
      rd_mux[ssf_pkg::B_WRITE_COLLISION_FLAG] = r.write_collision_flag;
      rd_mux[ssf_pkg::B_MODE_FAULT_FLAG] = r.mode_fault_flag;
      rd_mux[ssf_pkg::B_TXE] = r.tx_empty_flag;
      rd_mux[ssf_pkg::B_SELECT_IGNORE] = r.select_ignore;
      rd_mux[ssf_pkg::B_SLAVE_OUT_DISABLE] = r.slave_out_disable;
      rd_mux[ssf_pkg::B_ENH] = r.tx_empty_irq_enable;
    end else if (a == ssf_pkg::A_DATA) begin
      rd_mux = r.rxbuf;
    end else if (a == ssf_pkg::A_IRQ_ST) begin
      rd_mux = {5'h00, r.pend};
    end else if (a == ssf_pkg::A_IRQ_MASK) begin
      rd_mux = {5'h00, r.mask};
    end
  endfunction
  // ****************************************************
  // bus slave and pin synchronisers
  // ****************************************************
  ssf_axil u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_be(wr_be),
    .wr_err(~reg_hit(wr_addr)),
    .rd_stb(rd_stb),
    .rd_addr(rd_addr),
    .rd_word(rd_word),
    .rd_err(~reg_hit(rd_addr))
  );
  ssf_sync #(.W(4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .din({ss_n_in, sck_in, mosi_in, miso_in}),
    .dout(pins_s)
  );
  assign {ss_s, sck_s, mosi_s, miso_s} = pins_s;
  assign rd_word = {24'h000000, rd_mux(rd_addr)};
  // register access strobes; a disabled low byte ignores the write
  assign ctl_wr = wr_stb & wr_be & (wr_addr == ssf_pkg::A_CTRL);
  assign st_wr = wr_stb & wr_be & (wr_addr == ssf_pkg::A_STAT);
  assign dat_wr = wr_stb & wr_be & (wr_addr == ssf_pkg::A_DATA);
  assign msk_wr = wr_stb & wr_be & (wr_addr == ssf_pkg::A_IRQ_MASK);
  assign st_rd = rd_stb & (rd_addr == ssf_pkg::A_STAT);
  assign dat_rd = rd_stb & (rd_addr == ssf_pkg::A_DATA);
  assign ist_rd = rd_stb & (rd_addr == ssf_pkg::A_IRQ_ST);
  assign dat_acc = dat_wr | dat_rd;
  // slave takes part only when selected or select ignored
  assign slave_on = r.en & ~r.master_select & (r.select_ignore | ~ss_s);
  assign rxin = {r.shreg[6:0], r.master_select ? miso_s : r.samp};
  // ****************************************************
  // next state: clears first, then hardware sets win
  // ****************************************************
  always_comb begin
    next_r = r;
    rise_e = 1'b0;
    fall_e = 1'b0;
    xfer_end = 1'b0;
    mfault = 1'b0;
    next_r.sck_prev = sck_s;
    if (ctl_wr) begin
      next_r.serial_irq_enable = wr_data[ssf_pkg::B_ESP];
      next_r.en = wr_data[ssf_pkg::B_EN];
      next_r.master_select = wr_data[ssf_pkg::B_MASTER_SELECT];
    end
    // flags clear on writing a one
    if (st_wr) begin
      if (wr_data[ssf_pkg::B_DONE]) begin
        next_r.done = 1'b0;
      end
      if (wr_data[ssf_pkg::B_WRITE_COLLISION_FLAG]) begin
        next_r.write_collision_flag = 1'b0;
      end
      if (wr_data[ssf_pkg::B_MODE_FAULT_FLAG]) begin
        next_r.mode_fault_flag = 1'b0;
      end
      if (wr_data[ssf_pkg::B_TXE]) begin
        next_r.tx_empty_flag = 1'b0;
      end
      next_r.select_ignore = wr_data[ssf_pkg::B_SELECT_IGNORE];
      next_r.slave_out_disable = wr_data[ssf_pkg::B_SLAVE_OUT_DISABLE];
      next_r.tx_empty_irq_enable = wr_data[ssf_pkg::B_ENH];
    end
    if (msk_wr) begin
      next_r.mask = wr_data[2:0];
    end
    if (ist_rd) begin
      next_r.pend = 3'h0;
    end
    // status read arms the clear; the next data access fires it
    if (dat_acc && r.armed) begin
      next_r.done = 1'b0;
      next_r.write_collision_flag = 1'b0;
    end
    if (dat_acc) begin
      next_r.armed = 1'b0;
    end
    if (st_rd) begin
      next_r.armed = 1'b1;
    end
    // edge source: own divider as master, sampled pin as slave
    if (r.master_select && r.busy) begin
      next_r.div = r.div + 2'h1;
      if (r.div == ssf_pkg::SCK_HALF) begin
        next_r.div = 2'h0;
        next_r.sck = ~r.sck;
        rise_e = ~r.sck;
        fall_e = r.sck;
      end
    end else if (slave_on) begin
      rise_e = sck_s & ~r.sck_prev;
      fall_e = ~sck_s & r.sck_prev;
    end else if (!r.master_select) begin
      next_r.bits = 3'h0;
    end
    // slave preloads its shifter before the first edge
    if (slave_on && r.bits == 3'h0 && !r.sck_prev && r.txfull) begin
      next_r.shreg = r.txbuf;
      next_r.txfull = 1'b0;
      next_r.tx_empty_flag = 1'b1;
      next_r.pend[ssf_pkg::I_TXE] = 1'b1;
    end
    // mode 0; a master takes miso at the fall, sync lag eats half a bit
    if (rise_e) begin
      next_r.samp = r.master_select ? miso_s : mosi_s;
    end
    if (fall_e) begin
      next_r.shreg = rxin;
      next_r.bits = r.bits + 3'h1;
      xfer_end = (r.bits == ssf_pkg::LAST_BIT);
    end
    if (xfer_end) begin
      next_r.rxbuf = rxin;
      next_r.done = 1'b1;
      next_r.pend[ssf_pkg::I_DONE] = 1'b1;
      next_r.bits = 3'h0;
      if (r.txfull) begin
        next_r.shreg = r.txbuf;
        next_r.txfull = 1'b0;
        next_r.tx_empty_flag = 1'b1;
        next_r.pend[ssf_pkg::I_TXE] = 1'b1;
      end else begin
        next_r.busy = 1'b0; // slave echoes the received byte
      end
    end
    // collision on the select pin while master
    if (r.en && r.master_select && !r.select_ignore && !ss_s) begin
      mfault = 1'b1;
      next_r.mode_fault_flag = 1'b1;
      next_r.pend[ssf_pkg::I_MODE_FAULT_FLAG] = next_r.pend[ssf_pkg::I_MODE_FAULT_FLAG] | ~r.mode_fault_flag;
    end
    if (mfault || !r.en) begin
      next_r.busy = 1'b0;
      next_r.bits = 3'h0;
      next_r.sck = 1'b0;
      next_r.div = 2'h0;
    end
    // a write into a full buffer is dropped, shifter untouched
    if (dat_wr) begin
      if (next_r.txfull) begin
        next_r.write_collision_flag = 1'b1;
      end else if (r.en && r.master_select && !next_r.busy && !mfault) begin
        next_r.shreg = wr_data;
        next_r.tx_empty_flag = 1'b1;
        next_r.pend[ssf_pkg::I_TXE] = 1'b1;
        next_r.busy = 1'b1;
        next_r.bits = 3'h0;
        next_r.div = 2'h0;
      end else begin
        next_r.txbuf = wr_data;
        next_r.txfull = 1'b1;
      end
    end
    // registered pin drives and interrupt level
    next_r.mosi = next_r.shreg[7];
    next_r.miso = next_r.shreg[7];
    next_r.sck_oe = next_r.en & next_r.master_select;
    next_r.miso_oe = next_r.en & ~next_r.master_select & ~next_r.slave_out_disable &
      (next_r.select_ignore | ~ss_s);
    next_r.irq = next_r.serial_irq_enable & |(next_r.pend & next_r.mask &
      {next_r.tx_empty_irq_enable, 2'h3});
  end
  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.mask <= ssf_pkg::MASK_RESET;
    end else if (ce) begin
      r <= next_r;
    end
  end
  assign sck_out = r.sck;
  assign sck_oe = r.sck_oe;
  assign mosi_out = r.mosi;
  assign mosi_oe = r.sck_oe;
  assign miso_out = r.miso;
  assign miso_oe = r.miso_oe;
  assign irq = r.irq;
  // ****************************************************
  // checks
  // ****************************************************
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_stat_read;
    ce && st_rd && !dat_acc;
  endsequence
  sequence s_data_read;
    ce && dat_rd && !dat_wr && !st_rd && !xfer_end && r.armed;
  endsequence
  chk_done_set: assert property (
    (ce && xfer_end) |=> r.done && r.pend[ssf_pkg::I_DONE])
    else $error("transfer end did not set done");
  chk_seq_clear: assert property (
    s_stat_read ##[2:8] s_data_read |=> !r.done && !r.write_collision_flag)
    else $error("status then data read left a flag set");
  chk_write_collision_flag_set: assert property (
    (ce && dat_wr && r.txfull && !xfer_end) |=>
      r.write_collision_flag && r.txbuf == $past(r.txbuf))
    else $error("collision not flagged or buffer changed");
  chk_mode_fault_flag_set: assert property (
    (ce && r.en && r.master_select && !r.select_ignore && !ss_s) |=> r.mode_fault_flag)
    else $error("mode fault missed");
  chk_mode_fault_flag_hold: assert property (
    (ce && r.mode_fault_flag && !(st_wr && wr_data[ssf_pkg::B_MODE_FAULT_FLAG])) |=> r.mode_fault_flag)
    else $error("mode fault cleared without a write");
  chk_txe_gate: assert property (
    (ce && !next_r.tx_empty_irq_enable && next_r.pend[1:0] == 2'h0) |=> !irq)
    else $error("tx empty interrupted with its enable off");
  chk_irq_esp: assert property (
    (ce && !next_r.serial_irq_enable) |=> !irq && !r.serial_irq_enable)
    else $error("interrupt raised with serial enable off");
  chk_slave_idle: assert property (
    (ce && r.en && !r.master_select && !r.select_ignore && ss_s) |=> r.bits == 3'h0)
    else $error("deselected slave shifted");
  chk_miso_off: assert property (
    (ce && next_r.slave_out_disable) |=> !miso_oe)
    else $error("miso driven while output disabled");
  chk_master_go: assert property (
    (ce && dat_wr && !r.txfull && r.en && r.master_select && !r.busy &&
      !mfault) |=> r.busy && r.tx_empty_flag && !r.txfull ##1 r.busy)
    else $error("master write did not start a transfer");
  chk_rx_byte: assert property (
    (ce && xfer_end) |=> r.rxbuf == $past(rxin))
    else $error("received byte not stored");
endmodule

/* ssf_peer.sv */
// behavioural peer slave on the far side of the serial link
`timescale 1ns/1ps
module ssf_peer (
  input wire logic sck, // serial clock from the master
  input wire logic sel_n, // peer select, low active
  input wire logic mosi, // master-out line
  input wire logic [7:0] tx_byte, // byte the peer answers with
  output logic miso, // master-in line
  output logic miso_oe, // peer drives master-in
  output logic [7:0] rx_byte // last byte received whole
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  int n = 0;
  // released line shows the inverse so a stale bit never passes
  assign miso_oe = !sel_n;
  assign miso = sel_n ? ~sh[7] : sh[7];
  // first bit is ready before the first rising clock
  always @(negedge sel_n) begin
    sh = tx_byte;
    n = 0;
  end
  // sample on rise, msb first
  always @(posedge sck) begin
    if (!sel_n) begin
      rx = {rx[6:0], mosi};
      n = (n == 7) ? 0 : n + 1;
      if (n == 0) rx_byte = rx;
    end
  end
  // shift on fall, reload between bytes
  always @(negedge sck) begin
    if (!sel_n) sh = (n == 0) ? tx_byte : {sh[6:0], 1'b0};
  end
endmodule

/* ssf_spi_status_tb.sv */
// self-checking bench for the serial status flag block
`timescale 1ns/1ps
module ssf_spi_status_tb;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, resp;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic sck_tb = 0, mosi_tb = 0, ss_tb = 1, p_sel = 1, p_miso, p_oe;
  logic [7:0] rx_p, s;
  wire logic sck_w = sck_oe ? sck_out : sck_tb;
  wire logic mosi_w = mosi_oe ? mosi_out : mosi_tb;
  wire logic miso_w = miso_oe ? miso_out : p_miso;
  int err_count = 0, num_checks = 0;
  // ************************************************
  // clock, design and peer
  // ************************************************
  // 50 ns system clock
  always #25 aclk = ~aclk;
  ssf_spi_status DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
    .ss_n_in(ss_tb), .irq(irq));
  ssf_peer peer (.sck(sck_w), .sel_n(p_sel), .mosi(mosi_w),
    .tx_byte(8'h3c), .miso(p_miso), .miso_oe(p_oe), .rx_byte(rx_p));
  // ************************************************
  // bus and check tasks
  // ************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // each channel is released at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    resp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    v = rdata;
    resp = rresp;
    rready <= 0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(v, {24'h0, e});
  endtask
  // bounded wait, the watchdog catches a hang anyway
  task automatic wirq;
    for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge aclk);
  endtask
  // link clock at 400 ns, phase unrelated to the system clock
  task automatic sxfer(input logic [7:0] m);
    #13;
    for (int i = 7; i >= 0; i--) begin
      mosi_tb = m[i];
      #200 sck_tb = 1;
      s[i] = miso_w;
      #200 sck_tb = 0;
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  // watchdog well beyond the expected run
  initial begin
    #400000;
    err_count++;
    stop_test;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc(ssf_pkg::A_STAT, 8'h00);
    rd(8'h00);
    chk(resp, ssf_pkg::RESP_SLVERR);
    wr(8'h00, 8'hff);
    chk(resp, ssf_pkg::RESP_SLVERR);
    wr(ssf_pkg::A_CTRL, 8'h90);
    wr(ssf_pkg::A_CTRL, 8'hd0);
    wr(ssf_pkg::A_IRQ_MASK, 8'h07);
    chk(resp, ssf_pkg::RESP_OKAY);
    chk(sck_oe, 1);
    p_sel <= 0;
    wr(ssf_pkg::A_DATA, 8'ha5);
    repeat (4) @(posedge aclk);
    chk(irq, 0);
    wirq;
    chk(irq, 1);
    chk(rx_p, 8'ha5);
    rc(ssf_pkg::A_STAT, 8'h90);
    rc(ssf_pkg::A_IRQ_ST, 8'h05);
    chk(irq, 0);
    rc(ssf_pkg::A_DATA, 8'h3c);
    rc(ssf_pkg::A_STAT, 8'h10);
    // back to back, third byte collides with a full buffer
    wr(ssf_pkg::A_STAT, 8'h11);
    wr(ssf_pkg::A_DATA, 8'h11);
    wr(ssf_pkg::A_DATA, 8'h22);
    wr(ssf_pkg::A_DATA, 8'h33);
    chk(irq, 1);
    repeat (80) @(posedge aclk);
    chk(rx_p, 8'h22);
    rc(ssf_pkg::A_STAT, 8'hd1);
    rc(ssf_pkg::A_DATA, 8'h3c);
    rc(ssf_pkg::A_STAT, 8'h11);
    wr(ssf_pkg::A_STAT, 8'h10);
    rc(ssf_pkg::A_STAT, 8'h00);
    rd(ssf_pkg::A_IRQ_ST);
    // master with select pulled low
    p_sel <= 1;
    ss_tb <= 0;
    wirq;
    chk(irq, 1);
    ss_tb <= 1;
    rc(ssf_pkg::A_STAT, 8'h20);
    rd(ssf_pkg::A_DATA);
    rc(ssf_pkg::A_STAT, 8'h20);
    wr(ssf_pkg::A_STAT, 8'h20);
    rc(ssf_pkg::A_STAT, 8'h00);
    rd(ssf_pkg::A_IRQ_ST);
    wr(ssf_pkg::A_STAT, 8'h04);
    ss_tb <= 0;
    repeat (8) @(posedge aclk);
    rc(ssf_pkg::A_STAT, 8'h04);
    chk(irq, 0);
    ss_tb <= 1;
    // slave mode, link clock from the bench
    wr(ssf_pkg::A_CTRL, 8'h00);
    wr(ssf_pkg::A_STAT, 8'h00);
    wr(ssf_pkg::A_CTRL, 8'h80);
    wr(ssf_pkg::A_CTRL, 8'hc0);
    chk(miso_oe, 0);
    wr(ssf_pkg::A_DATA, 8'h5a);
    ss_tb <= 0;
    repeat (4) @(posedge aclk);
    chk(miso_oe, 1);
    sxfer(8'hc3);
    chk(s, 8'h5a);
    wirq;
    rc(ssf_pkg::A_DATA, 8'hc3);
    wr(ssf_pkg::A_STAT, 8'h02);
    repeat (2) @(posedge aclk);
    chk(miso_oe, 0);
    ss_tb <= 1;
    stop_test;
  end
endmodule
